/* design/dms_pkg.sv */
package dms_pkg;

    // Function register width and codes (3-bit function field)
    localparam int          FUNC_W          = 3;
    localparam logic [2:0]  FUNC_SEEK       = 3'h4;
    localparam logic [2:0]  FUNC_READ_ALL   = 3'h5;
    localparam logic [2:0]  FUNC_WRITE_ALL  = 3'h6;

    // Function register bit positions
    localparam int          FR_BIT0         = 0;
    localparam int          FR_BIT1         = 1;
    localparam int          FR_BIT2         = 2;

    // Sector address step that forces a head reload (octal 10 to 11)
    localparam int          SECT_W          = 4;
    localparam logic [3:0]  SECT_RELOAD_OLD = 4'h8;
    localparam logic [3:0]  SECT_RELOAD_NEW = 4'h9;

    // Clock and tag cycle timing
    localparam int          CLOCK_NS        = 100;
    localparam int          TAG_CYCLE_US    = 4;
    localparam int          TAG_CYCLE_CYC   = (TAG_CYCLE_US * 1000) / CLOCK_NS;

    // One-hot state indices
    localparam int          ST_IDLE         = 0;
    localparam int          ST_RECAL        = 1;
    localparam int          ST_SEEK         = 2;
    localparam int          ST_CLRHEAD      = 3;
    localparam int          ST_WRITE        = 4;
    localparam int          ST_INCHEAD      = 5;
    localparam int          ST_READ         = 6;
    localparam int          NUM_STATES      = 7;
    localparam logic [6:0]  STATE_RESET     = 7'h01;

    typedef enum logic [1:0] {
        TAG_IDLE,
        TAG_TIMED,
        TAG_LATCHED
    } dms_tag_type;

endpackage

/* design/dms_tag_timer.sv */
`timescale 1ns/10ps
// Tag cycle completion timer: a fixed count after start, or the
// trailing edge of the held strobe for read and write.
module dms_tag_timer
#(
    parameter int CYCLES = 40
)
(
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    input  wire logic i_start,
    input  wire logic i_rw_mode,
    input  wire logic i_rw_done,
    output logic      o_restart
);
    import dms_pkg::*;

    // Refuse a count that the counter cannot serve
    if (CYCLES < 1)
    begin : g_bad_cycles
        $error("dms_tag_timer: CYCLES must be at least 1");
    end

    localparam int CW = $clog2(CYCLES + 1);

    dms_tag_type   phase_reg;
    dms_tag_type   phase_next;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic          restart_next;

    wire timed_done = (count_reg == CW'(CYCLES - 1));

    always_comb
    begin
        phase_next   = phase_reg;
        count_next   = count_reg;
        restart_next = 1'b0;
        case (phase_reg)
            TAG_IDLE:
            begin
                count_next = '0;
                if (i_start)
                    phase_next = i_rw_mode ? TAG_LATCHED : TAG_TIMED;
            end
            TAG_TIMED:
            begin
                count_next = count_reg + CW'(1);
                if (timed_done)
                begin
                    phase_next   = TAG_IDLE;
                    restart_next = 1'b1;
                end
            end
            TAG_LATCHED:
            begin
                if (i_rw_done)
                begin
                    phase_next   = TAG_IDLE;
                    restart_next = 1'b1;
                end
            end
            default:
                phase_next = TAG_IDLE;
        endcase
        // A fresh start restarts the chain
        if (i_start && phase_reg != TAG_IDLE)
        begin
            phase_next = i_rw_mode ? TAG_LATCHED : TAG_TIMED;
            count_next = '0;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            phase_reg <= TAG_IDLE;
            count_reg <= '0;
            o_restart <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            count_reg <= count_next;
            o_restart <= restart_next;
        end
    end

    // Checker-only count since the last timed start, kept apart from count_reg
    int   chk_cnt;
    logic chk_on;

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            chk_on  <= 1'b0;
            chk_cnt <= 0;
        end
        else if (i_start)
        begin
            chk_on  <= !i_rw_mode;
            chk_cnt <= 0;
        end
        else if (chk_on)
        begin
            chk_cnt <= chk_cnt + 1;
            if (o_restart)
                chk_on <= 1'b0;
        end
    end

    tag_timed_len_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (chk_on && chk_cnt == CYCLES) |-> o_restart)
        else $error("tag cycle completion not at fixed count");

endmodule // dms_tag_timer

/* design/dms_major_state.sv */
`timescale 1ns/10ps
// Behaviour
// - Seven major states are one-hot; entering one clears all others.
// - Idle-set clears every other state and sets idle.
// - Controller clear is program clear OR host power clear.
// - Job-done flag forces idle.
// - Initiate-type functions go idle on tag cycle completion.
// - Sector end with word-count overflow forces idle.
// - Read-all/write-all go idle when sector steps octal 10 to 11.
// - Read, write, write-check go idle at every sector end.
// - Recal set by recal/idle class, bit 02, idle state, initiate pulse.
// - Recal/idle class is bit01 equals bit02 with bit00 zero; blocks seek request.
// - Seek request from clear head on tag completion and cylinder mismatch.
// - Seek set directly for initiate seek function when leaving idle.
// - Execute pulse enters clear head unless idle-set wins, clearing drive head address.
// - Format write waits for sector pulse, not idle, cylinder match, index.
// - Write-all normal write waits for sector pulse in read with match.
// - Normal data write in read with match, synced to delayed bit pulse.
// - Header match flag set when header equals cylinder, head, sector.
// - Head step set in write, no index, write-all, format, sector pulse.
// - Formatting alternates write and head step, seeks, repeats clear head.
// - Read entered from clear head on tag completion with cylinder match.
// - Seek request clears sync flop; unit-ready rise re-enables seek-to-read path.
// - Tag cycle completes after 4 us, or trailing strobe for read/write.
module dms_major_state
(
    input  wire logic                        i_clock,
    input  wire logic                        i_sys_rst,
    input  wire logic [dms_pkg::FUNC_W-1:0]  i_function_code,
    input  wire logic                        i_initiate_type_function,
    input  wire logic                        i_transfer_function,
    input  wire logic                        i_initiate_pulse,
    input  wire logic                        i_execute_pulse,
    input  wire logic                        i_program_controller_clear,
    input  wire logic                        i_io_power_clear,
    input  wire logic                        i_job_done_flag,
    input  wire logic                        i_word_count_overflow,
    input  wire logic                        i_sector_end,
    input  wire logic                        i_head_address_step,
    input  wire logic                        i_format_switch,
    input  wire logic [7:0]                  i_cylinder_address_register,
    input  wire logic [7:0]                  i_drive_cylinder_position,
    input  wire logic [35:0]                 i_header_word,
    input  wire logic                        i_header_valid,
    input  wire logic [4:0]                  i_head_address_register,
    input  wire logic [dms_pkg::SECT_W-1:0]  i_sector_address_register,
    input  wire logic                        i_sector_pulse,
    input  wire logic                        i_index_pulse,
    input  wire logic                        i_selected_unit_ready,
    input  wire logic                        i_delayed_bit_timing_pulse,
    input  wire logic                        i_rw_strobe_done,
    output logic                             o_idle,
    output logic                             o_recal,
    output logic                             o_seek,
    output logic                             o_head_clear_state,
    output logic                             o_write,
    output logic                             o_head_step,
    output logic                             o_read,
    output logic                             o_header_match_flag,
    output logic                             o_tag_restart
);
    import dms_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three flops, change counts when stages 2 and 3 agree

    logic [2:0] sp_sync_reg;
    logic [2:0] ix_sync_reg;
    logic [2:0] rdy_sync_reg;
    logic       sp_level_reg;
    logic       ix_level_reg;
    logic       rdy_level_reg;

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            sp_sync_reg  <= 3'h0;
            ix_sync_reg  <= 3'h0;
            // Ready idles high: start there so no false rise follows reset
            rdy_sync_reg <= 3'h7;
        end
        else
        begin
            sp_sync_reg  <= {sp_sync_reg[1:0], i_sector_pulse};
            ix_sync_reg  <= {ix_sync_reg[1:0], i_index_pulse};
            rdy_sync_reg <= {rdy_sync_reg[1:0], i_selected_unit_ready};
        end
    end

    wire sp_agree  = (sp_sync_reg[1] == sp_sync_reg[2]);
    wire ix_agree  = (ix_sync_reg[1] == ix_sync_reg[2]);
    wire rdy_agree = (rdy_sync_reg[1] == rdy_sync_reg[2]);

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            sp_level_reg  <= 1'b0;
            ix_level_reg  <= 1'b0;
            rdy_level_reg <= 1'b1;
        end
        else
        begin
            if (sp_agree)
                sp_level_reg <= sp_sync_reg[2];
            if (ix_agree)
                ix_level_reg <= ix_sync_reg[2];
            if (rdy_agree)
                rdy_level_reg <= rdy_sync_reg[2];
        end
    end

    wire sector_rise = sp_agree && sp_sync_reg[2] && !sp_level_reg;
    wire index_rise  = ix_agree && ix_sync_reg[2] && !ix_level_reg;
    wire ready_rise  = rdy_agree && rdy_sync_reg[2] && !rdy_level_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Function decode

    logic [NUM_STATES-1:0] state_reg;
    logic [NUM_STATES-1:0] state_next;

    wire in_idle    = state_reg[ST_IDLE];
    wire in_seek    = state_reg[ST_SEEK];
    wire in_clrhead = state_reg[ST_CLRHEAD];
    wire in_write   = state_reg[ST_WRITE];
    wire in_read    = state_reg[ST_READ];
    wire normal_sw  = !i_format_switch;
    wire tag_restart;

    wire recal_idle_class = (i_function_code[FR_BIT1] == i_function_code[FR_BIT2])
                            && !i_function_code[FR_BIT0];
    wire function_is_seek = (i_function_code == FUNC_SEEK);
    wire all_function     = (i_function_code == FUNC_READ_ALL)
                            || (i_function_code == FUNC_WRITE_ALL);
    wire write_all_fn     = (i_function_code == FUNC_WRITE_ALL);
    wire cylinder_match   = (i_cylinder_address_register == i_drive_cylinder_position);

    ////////////////////////////////////////////////////////////////////////////
    // Index-seen and header-match flags

    logic index_seen_reg;
    logic header_match_reg;

    // Index seen until the next sector pulse
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            index_seen_reg <= 1'b0;
        else if (index_rise)
            index_seen_reg <= 1'b1;
        else if (sector_rise)
            index_seen_reg <= 1'b0;
    end

    // header compare against cylinder, head, sector
    wire header_equal = (i_header_word[35:28] == i_cylinder_address_register)
                        && (i_header_word[27:23] == i_head_address_register)
                        && (i_header_word[21:18] == i_sector_address_register);

    // Set wins over the clear when leaving read
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            header_match_reg <= 1'b0;
        else if (i_header_valid && header_equal)
            header_match_reg <= 1'b1;
        else if (!in_read)
            header_match_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Set conditions

    wire controller_clear = i_program_controller_clear || i_io_power_clear;

    wire set_idle = controller_clear
                    || i_job_done_flag
                    || (tag_restart && i_initiate_type_function)
                    || (i_word_count_overflow && i_sector_end)
                    || (all_function && i_head_address_step)
                    || (!all_function && i_transfer_function && i_sector_end);

    wire set_recal = recal_idle_class && i_initiate_pulse
                     && i_function_code[FR_BIT2] && in_idle;

    // seek request from clear head; blocks it for recal/idle
    wire seek_request = !recal_idle_class && in_clrhead && tag_restart && !cylinder_match;

    wire direct_seek = function_is_seek && i_initiate_type_function
                       && in_idle && i_initiate_pulse;
    wire set_seek    = seek_request || direct_seek;

    wire set_clrhead = i_execute_pulse;

    wire waf_write = write_all_fn && i_format_switch && sector_rise && !in_idle
                     && cylinder_match && index_seen_reg && !in_write;
    wire wan_write = write_all_fn && normal_sw && sector_rise && in_read
                     && header_match_reg;
    wire wdn_write = !all_function && i_transfer_function && in_read
                     && header_match_reg && i_delayed_bit_timing_pulse;
    wire set_write = waf_write || wan_write || wdn_write;

    wire set_inchead = in_write && !index_seen_reg && write_all_fn
                       && i_format_switch && sector_rise;

    // sync flop blocks the seek-to-read path until ready rises
    logic ready_sync_reg;
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            ready_sync_reg <= 1'b1;
        else if (seek_request)
            ready_sync_reg <= 1'b0;
        else if (ready_rise)
            ready_sync_reg <= 1'b1;
    end

    wire read_direct = !function_is_seek && !recal_idle_class && normal_sw
                       && cylinder_match && in_clrhead && tag_restart;
    // Flop already holds the ready edge; testing the edge again would miss it
    // read after seek completes
    wire read_after_seek = in_seek && normal_sw && !function_is_seek
                           && ready_sync_reg;
    wire set_read = read_direct || read_after_seek;

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // one-hot next state, idle first, then priority order
    always_comb
    begin
        state_next = state_reg;
        if (set_idle)
            state_next = STATE_RESET;
        else if (set_clrhead)
            state_next = 7'h01 << ST_CLRHEAD;
        else if (set_recal)
            state_next = 7'h01 << ST_RECAL;
        else if (set_seek)
            state_next = 7'h01 << ST_SEEK;
        else if (set_read)
            state_next = 7'h01 << ST_READ;
        else if (set_inchead)
            state_next = 7'h01 << ST_INCHEAD;
        else if (set_write)
            state_next = 7'h01 << ST_WRITE;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            state_reg <= STATE_RESET;
        else
            state_reg <= state_next;
    end

    // Start a tag cycle on each entry to a state other than idle; read and write hold the strobe
    wire state_entry = (state_next != state_reg) && !set_idle;
    wire rw_entry    = set_read || set_write;

    dms_tag_timer #(
        .CYCLES (TAG_CYCLE_CYC)
    ) u_tag_timer (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_start   (state_entry),
        .i_rw_mode (rw_entry && !set_clrhead && !set_seek),
        .i_rw_done (i_rw_strobe_done),
        .o_restart (tag_restart)
    );

    assign o_idle              = state_reg[ST_IDLE];
    assign o_recal             = state_reg[ST_RECAL];
    assign o_seek              = state_reg[ST_SEEK];
    assign o_head_clear_state  = state_reg[ST_CLRHEAD];
    assign o_write             = state_reg[ST_WRITE];
    assign o_head_step         = state_reg[ST_INCHEAD];
    assign o_read              = state_reg[ST_READ];
    assign o_header_match_flag = header_match_reg;
    assign o_tag_restart       = tag_restart;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence clear_seen;
        controller_clear;
    endsequence

    one_hot_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        $onehot(state_reg))
        else $error("major state not one-hot");

    clear_idle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        clear_seen |=> o_idle)
        else $error("clear did not reach idle");

    done_idle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_job_done_flag |=> (o_idle && !o_read && !o_write))
        else $error("job done did not force idle");

    wc_idle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_word_count_overflow && i_sector_end) |=> o_idle)
        else $error("overflow sector end not idle");

    recal_entry_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        $rose(o_recal) |-> $past(in_idle) && $past(i_function_code[FR_BIT2]))
        else $error("recal entered without idle and bit 02");

    exec_head_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_execute_pulse && !set_idle) |=> o_head_clear_state)
        else $error("execute did not enter clear head");

    seek_block_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        recal_idle_class |-> !seek_request)
        else $error("seek request for recal or idle class");

    read_direct_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (read_direct && !set_idle && !set_clrhead && !set_recal && !set_seek)
        |=> o_read ##0 $past(o_head_clear_state))
        else $error("read not entered from clear head");

    sync_block_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        seek_request |=> !ready_sync_reg)
        else $error("seek request did not block read path");

endmodule // dms_major_state

/* testbench/dms_drive_model.sv */
`timescale 1ns/10ps
module dms_drive_model
#(
    parameter int SEEK_CYC = 60,
    parameter int SECT_CYC = 32
)
(
    input  wire logic i_clock,
    input  wire logic i_seek,
    input  wire logic i_spin,
    output logic      o_sector_pulse,
    output logic      o_index_pulse,
    output logic      o_unit_ready
);
    int   busy_cnt = 0;
    int   rot_cnt  = 0;
    logic seek_reg = 1'b0;

    // ready falls while the arm moves, rises once settled
    always @(posedge i_clock)
    begin
        seek_reg <= i_seek;
        if (i_seek && !seek_reg)
            busy_cnt <= SEEK_CYC;
        else if (busy_cnt > 0)
            busy_cnt <= busy_cnt - 1;
        rot_cnt <= i_spin ? (rot_cnt + 1) % (4 * SECT_CYC) : 0;
    end

    assign o_unit_ready = (busy_cnt == 0);
    // Pulses last 3 cycles so the pin synchronisers see them
    assign o_sector_pulse = i_spin && ((rot_cnt % SECT_CYC) < 3);
    assign o_index_pulse = i_spin && (rot_cnt >= 2 * SECT_CYC - 12)
                           && (rot_cnt < 2 * SECT_CYC - 9);
endmodule // dms_drive_model

/* testbench/test_dms_major_state.sv */
`timescale 1ns/10ps
module test_dms_major_state;
    import dms_pkg::*;

    logic        clock = 0, sys_rst = 1, init_type = 0, trans = 0, init_p = 0;
    logic        exec_p = 0, pclr = 0, pwr_clr = 0, job_done = 0, wc_ovf = 0;
    logic        sect_end = 0, har_step = 0, fmt = 0, hdr_valid = 0, dbit = 0;
    logic        spin = 0, rw_done = 0;
    logic [2:0]  func = 0;
    logic [7:0]  cylinder_address_register = 0, dcyl = 0;
    logic [35:0] hdr = 0;
    logic [4:0]  head_address_register = 0;
    logic [3:0]  sector_address_register = 0;
    logic        sect_p, idx_p, ready;
    logic        o_idle, o_recal, o_seek, o_clrh, o_write, o_step, o_read;
    logic        o_match, o_tag_restart;
    wire  [6:0]  seen_st = {o_read, o_step, o_write, o_clrh, o_seek, o_recal, o_idle};
    int          fails = 0, num_checks = 0, seed, k;

    initial
    begin
        forever #50 clock = ~clock;
    end

    dms_major_state dms_major_state_inst (.i_clock(clock), .i_sys_rst(sys_rst),
        .i_function_code(func), .i_initiate_type_function(init_type),
        .i_transfer_function(trans), .i_initiate_pulse(init_p), .i_execute_pulse(exec_p),
        .i_program_controller_clear(pclr), .i_io_power_clear(pwr_clr),
        .i_job_done_flag(job_done), .i_word_count_overflow(wc_ovf), .i_sector_end(sect_end),
        .i_head_address_step(har_step), .i_format_switch(fmt),
        .i_cylinder_address_register(cylinder_address_register), .i_drive_cylinder_position(dcyl),
        .i_header_word(hdr), .i_header_valid(hdr_valid), .i_head_address_register(head_address_register),
        .i_sector_address_register(sector_address_register), .i_sector_pulse(sect_p), .i_index_pulse(idx_p),
        .i_selected_unit_ready(ready), .i_delayed_bit_timing_pulse(dbit),
        .i_rw_strobe_done(rw_done), .o_idle(o_idle), .o_recal(o_recal), .o_seek(o_seek),
        .o_head_clear_state(o_clrh), .o_write(o_write), .o_head_step(o_step),
        .o_read(o_read), .o_header_match_flag(o_match), .o_tag_restart(o_tag_restart));

    dms_drive_model dms_drive_model_inst (.i_clock(clock), .i_seek(o_seek), .i_spin(spin),
        .o_sector_pulse(sect_p), .o_index_pulse(idx_p), .o_unit_ready(ready));

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic step(input int n = 1);
        repeat (n) @(posedge clock);
        #10;
    endtask

    task automatic check_state(input int exp_st);
        logic [6:0] e;
        e = 7'h01 << exp_st;
        num_checks++;
        if (seen_st !== e)
        begin
            fails++;
            $display("wrong value state expected %h seen %h", e, seen_st);
        end
    endtask

    task automatic check_val(input string name, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value %s expected %0h seen %0h", name, e, s);
        end
    endtask

    // Bounded poll; running out counts as a failure and ends the run
    task automatic wait_state(input int st, input int limit);
        int n;
        n = 0;
        while (seen_st[st] !== 1'b1 && n < limit)
        begin
            step();
            n++;
        end
        if (n >= limit)
        begin
            fails++;
            give_verdict();
        end
        else
            check_state(st);
    endtask

    task automatic wait_restart();
        int n;
        n = 0;
        while (o_tag_restart !== 1'b1 && n < 200)
        begin
            step();
            n++;
        end
        if (n >= 200)
        begin
            fails++;
            give_verdict();
        end
        else
            check_val("tag cycle length", TAG_CYCLE_CYC, n);
    endtask

    task automatic to_read();
        exec_p = 1;
        step();
        exec_p = 0;
        check_state(ST_CLRHEAD);
        wait_restart();
        step();
        check_state(ST_READ);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 34117;
        step(10);
        sys_rst = 0;
        check_state(ST_IDLE);
        step(4);
        cylinder_address_register = 8'($random(seed));
        dcyl = cylinder_address_register;
        head_address_register = 5'($random(seed));
        sector_address_register = 4'($random(seed));
        func = 3'h1;
        trans = 1;
        to_read();
        // Held read strobe ends the tag cycle on the first edge that samples it high
        rw_done = 1;
        step();
        rw_done = 0;
        check_val("strobe restart", 1, o_tag_restart);
        // Wrong cylinder in the header first, then the right one
        hdr = {cylinder_address_register ^ 8'h80, head_address_register, 1'b0, sector_address_register, 18'h0};
        hdr_valid = 1;
        step();
        hdr_valid = 0;
        step();
        check_val("header match", 0, o_match);
        hdr = {cylinder_address_register, head_address_register, 1'b0, sector_address_register, 18'h0};
        hdr_valid = 1;
        step();
        hdr_valid = 0;
        step();
        check_val("header match", 1, o_match);
        dbit = 1;
        step();
        dbit = 0;
        check_state(ST_WRITE);
        for (k = 0; k < 2; k++)
        begin
            exec_p = 1;
            step();
            exec_p = 0;
            {pclr, pwr_clr} = 2'b01 << k;
            step();
            {pclr, pwr_clr} = 2'b00;
            check_state(ST_IDLE);
        end
        dcyl = cylinder_address_register ^ 8'h01;
        exec_p = 1;
        step();
        exec_p = 0;
        wait_restart();
        step();
        check_state(ST_SEEK);
        wait_state(ST_READ, 200);
        check_val("unit ready", 1, ready);
        dcyl = cylinder_address_register;
        trans = 0;
        sect_end = 1;
        step();
        sect_end = 0;
        check_state(ST_READ);
        for (k = 0; k < 4; k++)
        begin
            to_read();
            wc_ovf = (k == 0);
            trans = (k == 1);
            func = (k == 2) ? FUNC_READ_ALL : 3'h1;
            sect_end = (k < 2);
            har_step = (k == 2);
            job_done = (k == 3);
            step();
            {wc_ovf, trans, sect_end, har_step, job_done} = 5'h00;
            check_state(ST_IDLE);
        end
        // Initiate with and without the recal class code
        init_type = 1;
        func = 3'h2;
        init_p = 1;
        step();
        init_p = 0;
        step();
        check_state(ST_IDLE);
        func = 3'h6;
        init_p = 1;
        step();
        init_p = 0;
        check_state(ST_RECAL);
        wait_restart();
        step();
        check_state(ST_IDLE);
        func = FUNC_SEEK;
        init_p = 1;
        step();
        init_p = 0;
        wait_state(ST_SEEK, 3);
        wait_state(ST_IDLE, 60);
        init_type = 0;
        func = FUNC_WRITE_ALL;
        fmt = 1;
        exec_p = 1;
        step();
        exec_p = 0;
        wait_restart();
        step(2);
        check_state(ST_CLRHEAD);
        spin = 1;
        wait_state(ST_WRITE, 300);
        wait_state(ST_INCHEAD, 300);
        wait_state(ST_WRITE, 300);
        give_verdict();
    end
endmodule // test_dms_major_state
